// ### rtl/xcvr_pkg.sv
package xcvr_pkg;

	// ****************************************
	// register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_SAMPLE_A = 8'h08;
	localparam logic [7:0] OFS_SAMPLE_B = 8'h0C;
	localparam logic [7:0] OFS_STORE_A  = 8'h10;
	localparam logic [7:0] OFS_STORE_B  = 8'h14;
	localparam logic [7:0] OFS_TEST_A   = 8'h18;
	localparam logic [7:0] OFS_TEST_B   = 8'h1C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_TEST_MODE   = 0;
	localparam int CTRL_SAMPLE_REQ  = 1;
	localparam int CTRL_TEST_DRV_A  = 2;
	localparam int CTRL_TEST_DRV_B  = 3;
	localparam int STAT_TEST_MODE   = 0;
	localparam int STAT_SAMPLE_DONE = 1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic       RST_TEST_MODE = 1'b0;
	localparam logic       RST_TEST_DRV  = 1'b0;
	localparam logic       OE_N_OFF      = 1'b1;
	localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

	// register selector produced by the address decode
	typedef enum logic [8:0] {
		SEL_CTRL     = 9'h001,
		SEL_STATUS   = 9'h002,
		SEL_SAMPLE_A = 9'h004,
		SEL_SAMPLE_B = 9'h008,
		SEL_STORE_A  = 9'h010,
		SEL_STORE_B  = 9'h020,
		SEL_TEST_A   = 9'h040,
		SEL_TEST_B   = 9'h080,
		SEL_NONE     = 9'h100
	} reg_sel_t;

	// per-section control pins
	typedef struct packed {
		logic outputEnableN;
		logic directionSelect;
		logic aToBSourceSelect;
		logic bToASourceSelect;
		logic aToBCaptureClock;
		logic bToACaptureClock;
	} sec_ctrl_t;

endpackage

// ### rtl/registered_bus_transceiver.sv
//
// Functional notes
// - OE low: DIR high drives B, low drives A
// - OE high: both ports released
// - A register loads port A on capture edge
// - A select low: live A onto B
// - A select high: stored A onto B
// - B register mirrors A path on its clock
// - B-to-A, select low: live B onto A
// - B-to-A, select high: stored B onto A
// - capture never gated by OE or DIR
// - each section has its own controls
// - test mode inhibits normal operation, test drives
// - pin sampling leaves function untouched
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module registered_bus_transceiver import xcvr_pkg::*; #(
	parameter int SECTION_BITS = 9,
	parameter int SECTIONS     = 2
) (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// section control pins
	input  wire sec_ctrl_t [SECTIONS-1:0]      sectionCtrl,
	// port a pins
	input  wire logic [SECTION_BITS*SECTIONS-1:0] portABitsIn,
	output logic      [SECTION_BITS*SECTIONS-1:0] portABitsOut,
	output logic      [SECTION_BITS*SECTIONS-1:0] portABitsOeN,
	// port b pins
	input  wire logic [SECTION_BITS*SECTIONS-1:0] portBBitsIn,
	output logic      [SECTION_BITS*SECTIONS-1:0] portBBitsOut,
	output logic      [SECTION_BITS*SECTIONS-1:0] portBBitsOeN
);

	localparam int W = SECTION_BITS * SECTIONS;

	// ****************************************
	// behaviour and timing notes
	// ****************************************
	// every pin input, data and control alike, passes two flip-flops first
	// data and control share that delay, so a capture edge and the data
	// that stood with it arrive at the storage registers together
	// a data, select, direction or enable change on the pins reaches the drive
	// outputs three core_clk edges later and a capture edge four; slower board logic never sees the difference
	// a capture clock is edge detected against a third stage, so it must
	// stay high and low for at least two core_clk cycles each
	// data must stand two cycles on each side of a capture rise; anything
	// quicker can be caught half old and half new across the bits
	// storage has no reset on purpose: it only ever holds bus values, and
	// a reset would hide a missing capture from the board logic
	// drive data has no reset either; while released its value is unseen
	// output enables are active low and come up released after reset
	// test mode stands in for scan test: it stops capture, and the pins
	// either carry the test pattern or are let go, one enable per port
	// the pin snapshot only copies synchronised values into software
	// registers; nothing on the data path ever reads it back
	// sections never share controls; a wide path ties them on the board
	// the register bus answers after one wait cycle, always the same,
	// so software timing never depends on the state of the buses
	// an unmapped address answers with an error and is otherwise ignored
	// all registers sit in one word each, data in the low bits

	// registers hold the whole pin vector in one word
	if (SECTION_BITS < 1 || SECTIONS < 1 || W > 32) begin : gBadParams
		$error("registered_bus_transceiver: width must be 1 to 32 bits");
	end

	// ****************************************
	// address decode
	// ****************************************
	function automatic reg_sel_t decode(input logic [7:0] addr);
		case (addr)
			OFS_CTRL:     decode = SEL_CTRL;
			OFS_STATUS:   decode = SEL_STATUS;
			OFS_SAMPLE_A: decode = SEL_SAMPLE_A;
			OFS_SAMPLE_B: decode = SEL_SAMPLE_B;
			OFS_STORE_A:  decode = SEL_STORE_A;
			OFS_STORE_B:  decode = SEL_STORE_B;
			OFS_TEST_A:   decode = SEL_TEST_A;
			OFS_TEST_B:   decode = SEL_TEST_B;
			default:      decode = SEL_NONE;
		endcase
	endfunction

	// ****************************************
	// source selection
	// ****************************************
	// shared by both directions: stored value when the select is high
	function automatic logic [SECTION_BITS-1:0] pickSource(
		input logic                    useStored,
		input logic [SECTION_BITS-1:0] stored,
		input logic [SECTION_BITS-1:0] live
	);
		pickSource = useStored ? stored : live;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic      [W-1:0]        aSync1_r;
	logic      [W-1:0]        aSync2_r;
	logic      [W-1:0]        bSync1_r;
	logic      [W-1:0]        bSync2_r;
	sec_ctrl_t [SECTIONS-1:0] ctrlSync1_r;
	sec_ctrl_t [SECTIONS-1:0] ctrlSync2_r;
	sec_ctrl_t [SECTIONS-1:0] ctrlPrev_r;

	// two stages on every pin; data and clocks share the delay so they stay aligned
	always_ff @(posedge core_clk) begin
		aSync1_r    <= portABitsIn;
		aSync2_r    <= aSync1_r;
		bSync1_r    <= portBBitsIn;
		bSync2_r    <= bSync1_r;
		ctrlSync1_r <= sectionCtrl;
		ctrlSync2_r <= ctrlSync1_r;
		ctrlPrev_r  <= ctrlSync2_r;
	end

	// ****************************************
	// software control state
	// ****************************************
	logic         testMode_r;
	logic         testDrvA_r;
	logic         testDrvB_r;
	logic         sampleDone_r;
	logic [W-1:0] sampleA_r;
	logic [W-1:0] sampleB_r;
	logic [W-1:0] testA_r;
	logic [W-1:0] testB_r;
	logic [W-1:0] storeAFlat;
	logic [W-1:0] storeBFlat;
	logic         apbWrite;
	logic         apbRead;
	reg_sel_t     sel;

	// a write is taken on the second access cycle, when pready is high; a read in the first, the wait cycle
	assign sel      = decode(paddr);
	assign apbWrite = psel & penable & pready & pwrite;
	assign apbRead  = psel & penable & ~pready & ~pwrite;

	// apb handshake: one wait cycle, then pready for one cycle
	// the fixed wait gives read data a full cycle to be selected and
	// registered, so prdata leaves a flip-flop like every other output
	// pslverr rides with pready and is low whenever pready is low
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & (sel == SEL_NONE);
		end
	end

	// read data captured in the wait cycle so it stands with pready
	// outside that single cycle prdata is held at zero, so a master that
	// samples late reads zero rather than a stale word
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata <= RDATA_ZERO;
		end else if (apbRead) begin
			prdata <= RDATA_ZERO;
			case (sel)
				SEL_CTRL: begin
					prdata[CTRL_TEST_MODE]  <= testMode_r;
					prdata[CTRL_TEST_DRV_A] <= testDrvA_r;
					prdata[CTRL_TEST_DRV_B] <= testDrvB_r;
				end
				SEL_STATUS: begin
					prdata[STAT_TEST_MODE]   <= testMode_r;
					prdata[STAT_SAMPLE_DONE] <= sampleDone_r;
				end
				SEL_SAMPLE_A: prdata[W-1:0] <= sampleA_r;
				SEL_SAMPLE_B: prdata[W-1:0] <= sampleB_r;
				SEL_STORE_A:  prdata[W-1:0] <= storeAFlat;
				SEL_STORE_B:  prdata[W-1:0] <= storeBFlat;
				SEL_TEST_A:   prdata[W-1:0] <= testA_r;
				SEL_TEST_B:   prdata[W-1:0] <= testB_r;
				default:      prdata <= RDATA_ZERO;
			endcase
		end else begin
			prdata <= RDATA_ZERO;
		end
	end

	// control register: test mode and test drive enables
	// the sample request bit is a strobe and is never stored here
	always_ff @(posedge core_clk) begin
		if (rst) begin
			testMode_r <= RST_TEST_MODE;
			testDrvA_r <= RST_TEST_DRV;
			testDrvB_r <= RST_TEST_DRV;
		end else if (apbWrite && sel == SEL_CTRL) begin
			testMode_r <= pwdata[CTRL_TEST_MODE];
			testDrvA_r <= pwdata[CTRL_TEST_DRV_A];
			testDrvB_r <= pwdata[CTRL_TEST_DRV_B];
		end
	end

	// test pattern registers, driven on the pins only in test mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			testA_r <= '0;
			testB_r <= '0;
		end else if (apbWrite) begin
			if (sel == SEL_TEST_A) testA_r <= pwdata[W-1:0];
			if (sel == SEL_TEST_B) testB_r <= pwdata[W-1:0];
		end
	end

	// snapshot of the pins; only observes, never feeds the data path
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sampleA_r <= '0;
			sampleB_r <= '0;
		end else if (apbWrite && sel == SEL_CTRL && pwdata[CTRL_SAMPLE_REQ]) begin
			sampleA_r <= aSync2_r;
			sampleB_r <= bSync2_r;
		end
	end

	// sticky done flag: a new sample wins over a clear in the same write
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sampleDone_r <= 1'b0;
		end else if (apbWrite && sel == SEL_CTRL && pwdata[CTRL_SAMPLE_REQ]) begin
			sampleDone_r <= 1'b1;
		end else if (apbWrite && sel == SEL_STATUS && pwdata[STAT_SAMPLE_DONE]) begin
			sampleDone_r <= 1'b0;
		end
	end

	// ****************************************
	// transceiver sections
	// ****************************************
	for (genvar s = 0; s < SECTIONS; s++) begin : gSec
		localparam int LO = s * SECTION_BITS;

		logic [SECTION_BITS-1:0] storeA_r;
		logic [SECTION_BITS-1:0] storeB_r;
		logic [SECTION_BITS-1:0] outA_r;
		logic [SECTION_BITS-1:0] outB_r;
		logic                    oeNA_r;
		logic                    oeNB_r;
		logic                    abEdge;
		logic                    baEdge;
		sec_ctrl_t               c;

		// each section reads only its own control pins
		// edges are seen in the first cycle the synchronised level is high, and
		// the data taken is the synchronised value of that same cycle
		assign c      = ctrlSync2_r[s];
		assign abEdge = c.aToBCaptureClock & ~ctrlPrev_r[s].aToBCaptureClock;
		assign baEdge = c.bToACaptureClock & ~ctrlPrev_r[s].bToACaptureClock;

		// no reset: contents hold until the next capture edge
		always_ff @(posedge core_clk) begin
			if (abEdge && !testMode_r) begin
				storeA_r <= aSync2_r[LO +: SECTION_BITS];
			end
			if (baEdge && !testMode_r) begin
				storeB_r <= bSync2_r[LO +: SECTION_BITS];
			end
		end

		// output data: test pattern, stored or live opposite-port value
		// data is chosen even while the port is released, so enabling the
		// drive never shows a stale word for a cycle
		// a live value driven back onto its own bus is not possible: the
		// enables below let both ports of a section drive at once only in test mode, with the test pattern
		always_ff @(posedge core_clk) begin
			if (testMode_r) begin
				outB_r <= testB_r[LO +: SECTION_BITS];
				outA_r <= testA_r[LO +: SECTION_BITS];
			end else begin
				outB_r <= pickSource(c.aToBSourceSelect, storeA_r, aSync2_r[LO +: SECTION_BITS]);
				outA_r <= pickSource(c.bToASourceSelect, storeB_r, bSync2_r[LO +: SECTION_BITS]);
			end
		end

		// output enables, active low, released at reset
		// test mode takes priority over the pins; outside it the output
		// enable pin wins over direction, so both ports go quiet together
		always_ff @(posedge core_clk) begin
			if (rst) begin
				oeNA_r <= OE_N_OFF;
				oeNB_r <= OE_N_OFF;
			end else if (testMode_r) begin
				oeNA_r <= ~testDrvA_r;
				oeNB_r <= ~testDrvB_r;
			end else if (c.outputEnableN) begin
				oeNA_r <= OE_N_OFF;
				oeNB_r <= OE_N_OFF;
			end else begin
				oeNB_r <= ~c.directionSelect;
				oeNA_r <= c.directionSelect;
			end
		end

		// all bits of a port share one enable flip-flop per section
		assign portABitsOut[LO +: SECTION_BITS] = outA_r;
		assign portBBitsOut[LO +: SECTION_BITS] = outB_r;
		assign portABitsOeN[LO +: SECTION_BITS] = {SECTION_BITS{oeNA_r}};
		assign portBBitsOeN[LO +: SECTION_BITS] = {SECTION_BITS{oeNB_r}};
		assign storeAFlat[LO +: SECTION_BITS]   = storeA_r;
		assign storeBFlat[LO +: SECTION_BITS]   = storeB_r;
	end

endmodule

// ### verification/bus_partner.sv
`timescale 1ns/1ps
// board logic on both buses; it lets go of every bit the section drives, so no contention
module bus_partner (
	// data the board offers
	input  wire logic [17:0] boardA,
	input  wire logic [17:0] boardB,
	// section drive, active-low enables
	input  wire logic [17:0] aOut,
	input  wire logic [17:0] aOeN,
	input  wire logic [17:0] bOut,
	input  wire logic [17:0] bOeN,
	// resolved bus levels
	output logic      [17:0] wireA,
	output logic      [17:0] wireB
);
	// per-bit resolution of each bus
	assign wireA = (aOut & ~aOeN) | (boardA & aOeN);
	assign wireB = (bOut & ~bOeN) | (boardB & bOeN);
endmodule

// ### verification/registered_bus_transceiver_monitor.sv
`timescale 1ns/1ps
module registered_bus_transceiver_monitor import xcvr_pkg::*; #(
	parameter int SECTION_BITS = 9,
	parameter int SECTIONS     = 2
) (
	// clock, reset and apb
	input wire logic                               core_clk,
	input wire logic                               rst,
	input wire logic                               psel,
	input wire logic                               penable,
	input wire logic                               pwrite,
	input wire logic [7:0]                         paddr,
	input wire logic [31:0]                        pwdata,
	input wire logic                               pready,
	// pins
	input wire sec_ctrl_t [SECTIONS-1:0]           sectionCtrl,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portABitsIn,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portABitsOut,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portABitsOeN,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portBBitsIn,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portBBitsOut,
	input wire logic [SECTION_BITS*SECTIONS-1:0]   portBBitsOeN
);
	logic       tm_r;
	logic [8:0] storeA_r;
	logic [8:0] storeB_r;
	sec_ctrl_t  c;
	assign c = sectionCtrl[0];
	wire runs = !c.outputEnableN && !tm_r;
	wire toB  = runs && c.directionSelect;
	wire toA  = runs && !c.directionSelect;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// test mode follows completed control writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tm_r <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
			tm_r <= pwdata[CTRL_TEST_MODE];
		end
	end
	// pins are stable around a capture edge, so raw sampling is safe
	always_ff @(posedge core_clk) begin
		if ($rose(c.aToBCaptureClock) && !tm_r) begin
			storeA_r <= portABitsIn[8:0];
		end
		if ($rose(c.bToACaptureClock) && !tm_r) begin
			storeB_r <= portBBitsIn[8:0];
		end
	end
	AST_ISOLATE: assert property (
		(c.outputEnableN && !tm_r)[*4] |-> &{portABitsOeN[8:0], portBBitsOeN[8:0]})
		else $error("port driven while disabled");
	AST_DRIVE_B: assert property (
		toB[*4] |-> portBBitsOeN[8:0] == 9'h000 && &portABitsOeN[8:0])
		else $error("b port not driven alone");
	AST_DRIVE_A: assert property (
		toA[*4] |-> portABitsOeN[8:0] == 9'h000 && &portBBitsOeN[8:0])
		else $error("a port not driven alone");
	AST_LIVE_AB: assert property (
		(toB && !c.aToBSourceSelect && $stable(portABitsIn[8:0]))[*4]
		|-> portBBitsOut[8:0] == portABitsIn[8:0]) else $error("live a data lost");
	AST_LIVE_BA: assert property (
		(toA && !c.bToASourceSelect && $stable(portBBitsIn[8:0]))[*4]
		|-> portABitsOut[8:0] == portBBitsIn[8:0]) else $error("live b data lost");
	AST_STORED_AB: assert property (
		(toB && c.aToBSourceSelect && $stable(c.aToBCaptureClock))[*6]
		|-> portBBitsOut[8:0] == storeA_r) else $error("stored a data lost");
	AST_STORED_BA: assert property (
		(toA && c.bToASourceSelect && $stable(c.bToACaptureClock))[*6]
		|-> portABitsOut[8:0] == storeB_r) else $error("stored b data lost");
	AST_APB_READY: assert property (psel && !penable |-> ##2 pready)
		else $error("ready late or early");
endmodule
bind registered_bus_transceiver registered_bus_transceiver_monitor #(
	.SECTION_BITS(SECTION_BITS), .SECTIONS(SECTIONS)) i_monitor (.core_clk, .rst, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .sectionCtrl, .portABitsIn, .portABitsOut,
	.portABitsOeN, .portBBitsIn, .portBBitsOut, .portBBitsOeN);

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import xcvr_pkg::*; ;
	// ****************************************
	// stimulus and expected bus levels
	// ****************************************
	localparam logic [17:0] CA = 18'h15A5A, CB = 18'h2A5A5, LA = 18'h3C0F0, LB = 18'h03F0F;
	localparam logic [17:0] ONES = 18'h3FFFF, NONE = 18'h00000, PAT = 18'h0A5C3;
	typedef struct packed {
		logic [7:0]  ctl;
		logic [17:0] aLvl, aOeN, bLvl, bOeN;
	} row_t;
	// per section {oe, dir, sab, sba}; a level is the output or-ed with its disable
	row_t rows [6] = '{
		'{8'h44, ONES, ONES, LA, NONE},
		'{8'h66, ONES, ONES, CA, NONE},
		'{8'h00, LB, NONE, ONES, ONES},
		'{8'h11, CB, NONE, ONES, ONES},
		'{8'hFF, ONES, ONES, ONES, ONES},
		'{8'h41, 18'h3FFA5, 18'h3FE00, 18'h3C1FF, 18'h001FF}
	};
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [7:0]  paddr  = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr;
	logic [17:0] pa = NONE, pb = NONE, wireA, wireB, aOut, aOeN, bOut, bOeN;
	sec_ctrl_t [1:0] sectionCtrl = 12'h820;
	int err_total = 0, samples_checked = 0, cyc = 0;
	registered_bus_transceiver #(.SECTION_BITS(9), .SECTIONS(2)) i_dut (.core_clk, .rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sectionCtrl,
		.portABitsIn(wireA), .portABitsOut(aOut), .portABitsOeN(aOeN),
		.portBBitsIn(wireB), .portBBitsOut(bOut), .portBBitsOeN(bOeN));
	bus_partner i_partner (.boardA(pa), .boardB(pb), .aOut, .aOeN, .bOut, .bOeN, .wireA, .wireB);
	always #2.5 core_clk = ~core_clk;
	// the run needs about 200 cycles, so this only trips on a hang
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// both sections get the same capture clock level
	task automatic setCtl(input logic [7:0] c, input logic ck);
		for (int s = 0; s < 2; s++) begin
			sectionCtrl[s] <= {c[4*s+3 -: 4], ck, ck};
		end
	endtask
	// capture with outputs off, pins held steady well around the edge
	task automatic cap();
		setCtl(8'h88, 1'b0);
		pa <= CA;
		pb <= CB;
		w(6);
		setCtl(8'h88, 1'b1);
		w(4);
		setCtl(8'h88, 1'b0);
		w(4);
	endtask
	// one apb transfer; the extra edge keeps two calls from colliding
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	initial begin
		w(10);
		rst <= 1'b0;
		w(1);
		for (int i = 0; i < 6; i++) begin
			cap();
			pa <= LA;
			pb <= LB;
			setCtl(rows[i].ctl, 1'b0);
			w(6);
			chk("portA", 32'(rows[i].aLvl), 32'(aOut | aOeN));
			chk("portAOeN", 32'(rows[i].aOeN), 32'(aOeN));
			chk("portB", 32'(rows[i].bLvl), 32'(bOut | bOeN));
			chk("portBOeN", 32'(rows[i].bOeN), 32'(bOeN));
		end
		// pin sampling while b carries live a
		setCtl(8'h44, 1'b0);
		w(6);
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0002, rd);
		apb(1'b0, OFS_SAMPLE_A, 32'h0000_0000);
		chk("sampleA", 32'(LA), rd);
		chk("portBSampled", 32'(LA), 32'(bOut | bOeN));
		apb(1'b0, OFS_STORE_A, 32'h0000_0000);
		chk("storeA", 32'(CA), rd);
		apb(1'b0, OFS_STORE_B, 32'h0000_0000);
		chk("storeB", 32'(CB), rd);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("unmappedErr", 32'h0000_0001, 32'(er));
		chk("unmappedData", RDATA_ZERO, rd);
		// test mode overrides the transceiver and ignores capture edges
		apb(1'b1, OFS_TEST_A, 32'(PAT));
		apb(1'b1, OFS_CTRL, 32'h0000_0005);
		w(6);
		chk("testA", 32'(PAT), 32'(aOut | aOeN));
		chk("testBOeN", 32'(ONES), 32'(bOeN));
		setCtl(8'h44, 1'b1);
		w(4);
		setCtl(8'h44, 1'b0);
		w(4);
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		apb(1'b0, OFS_STORE_A, 32'h0000_0000);
		chk("storeAHeld", 32'(CA), rd);
		// reset releases the buses at once but leaves storage alone
		setCtl(8'h00, 1'b0);
		w(6);
		rst <= 1'b1;
		setCtl(8'h88, 1'b0);
		w(2);
		chk("resetOeN", 32'(ONES), 32'(aOeN));
		chk("resetReady", 32'h0000_0000, 32'(pready));
		rst <= 1'b0;
		w(1);
		apb(1'b0, OFS_STORE_A, 32'h0000_0000);
		chk("storeAKept", 32'(CA), rd);
		report_and_stop();
	end
endmodule
